//--- core/reset_state_and_flag_logic.v
`timescale 1ns/1ns
`include "reset_state_map.vh"
module reset_state_and_flag_logic #(
    parameter PC_W   = 14,
    parameter SP_W   = 3,
    parameter PORT_W = 8
) (
    input  wire              ref_clk,
    input  wire              rst,
    input  wire              power_on,
    input  wire              external_reset_pin_n,
    input  wire              low_voltage_reset,
    input  wire              watchdog_timer_timeout,
    input  wire              halt_exec,
    input  wire              watchdog_clear,
    input  wire              wake_up,
    output reg  [PC_W-1:0]   pc_value,
    output reg  [SP_W-1:0]   sp_value,
    output reg               core_reset,
    output reg               watchdog_timeout_flag,
    output reg               power_down_flag,
    output reg               power_down,
    output reg               interrupt_enable_clear,
    output reg               watchdog_timer_restart,
    output reg               timers_off,
    output reg  [PORT_W-1:0] port_data,
    output reg  [PORT_W-1:0] port_dir,
    output reg  [2:0]        reset_cause
);
    // The pin and the supply monitor are asynchronous to ref_clk, so each of them
    // passes two flip-flops before any logic reads it. Only the second stage of a
    // synchroniser is ever read, which keeps a metastable first stage out of the
    // reset decode.
    reg  [1:0] pin_sync;
    reg  [1:0] lvr_sync;
    reg  [2:0] next_cause;
    wire       pin_reset;
    wire       lvr_reset;
    wire       full_reset;
    wire       run_reset;
    wire       core_init;

    // Picks the one reset cause that acts in this cycle. Power-on outranks
    // everything; a pin or low-voltage reset always reinitialises the core, so
    // it outranks a watchdog time-out that arrives in the same cycle.
    function [2:0] pick_cause;
        input full_req;
        input run_req;
        input tmo_req;
        input asleep;
        begin
            if (full_req)
                pick_cause = `CAUSE_POR;
            else if (run_req)
                pick_cause = `CAUSE_PIN;
            else if (tmo_req && asleep)
                pick_cause = `CAUSE_WDT_PD;
            else if (tmo_req)
                pick_cause = `CAUSE_WDT_RUN;
            else
                pick_cause = `CAUSE_NONE;
        end
    endfunction

    // True for every cause that restarts the whole machine. A time-out in
    // power-down is not one of them: it resumes the program from the reset
    // vector and leaves ports, timers and interrupt enables as they were.
    function reinits_core;
        input [2:0] cause;
        begin
            case (cause)
                `CAUSE_POR,
                `CAUSE_PIN,
                `CAUSE_WDT_RUN:
                    reinits_core = `PULSE_ON;
                default:
                    reinits_core = `PULSE_OFF;
            endcase
        end
    endfunction

    assign pin_reset  = ~pin_sync[1];
    assign lvr_reset  = lvr_sync[1];
    assign full_reset = power_on | rst;
    assign run_reset  = pin_reset | lvr_reset;
    assign core_init  = reinits_core(next_cause);

    always @*
    begin
        next_cause = pick_cause(full_reset, run_reset, watchdog_timer_timeout, power_down);
    end

    // The pin stage resets to the released level of the pin. Resetting it to
    // zero would make the pin look pressed for two cycles after rst and fire a
    // spurious pin reset that pulses every reset strobe again.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            pin_sync <= `PIN_IDLE;
            lvr_sync <= `LVR_IDLE;
        end
        else
        begin
            pin_sync <= {pin_sync[0], external_reset_pin_n};
            lvr_sync <= {lvr_sync[0], low_voltage_reset};
        end
    end

    // The cause register tells software which reset acted in the last cycle.
    always @(posedge ref_clk)
    begin
        reset_cause <= next_cause;
    end

    // Every cause, the time-out in power-down included, restarts the program
    // at the reset vector. Between resets the core owns these values, so the
    // block simply holds them.
    always @(posedge ref_clk)
    begin
        case (next_cause)
            `CAUSE_POR,
            `CAUSE_PIN,
            `CAUSE_WDT_RUN:
            begin
                pc_value <= `PC_RESET;
                sp_value <= `SP_TOP;
            end
            `CAUSE_WDT_PD:
            begin
                pc_value <= `PC_RESET;
                sp_value <= `SP_RESET;
            end
            default:
            begin
                pc_value <= pc_value;
                sp_value <= sp_value;
            end
        endcase
    end

    // Status flags. Both events that set a flag outrank a clear instruction in
    // the same cycle: a time-out becomes a reset cause, and halt is tested
    // before the clear, so an event is never lost to a clear.
    always @(posedge ref_clk)
    begin
        case (next_cause)
            `CAUSE_POR:
            begin
                watchdog_timeout_flag <= `FLAG_CLR;
                power_down_flag       <= `FLAG_CLR;
            end
            `CAUSE_PIN:
            begin
                // A pin held low keeps the core in reset; the flags stay put.
                watchdog_timeout_flag <= watchdog_timeout_flag;
                power_down_flag       <= power_down_flag;
            end
            `CAUSE_WDT_RUN:
            begin
                watchdog_timeout_flag <= `FLAG_SET;
                power_down_flag       <= power_down_flag;
            end
            `CAUSE_WDT_PD:
            begin
                watchdog_timeout_flag <= `FLAG_SET;
                power_down_flag       <= `FLAG_SET;
            end
            default:
            begin
                // Halt also clears the time-out flag, so a later time-out in
                // power-down can be told apart from an ordinary wake event.
                if (halt_exec)
                begin
                    power_down_flag       <= `FLAG_SET;
                    watchdog_timeout_flag <= `FLAG_CLR;
                end
                else if (watchdog_clear)
                begin
                    power_down_flag       <= `FLAG_CLR;
                    watchdog_timeout_flag <= `FLAG_CLR;
                end
                else
                begin
                    power_down_flag       <= power_down_flag;
                    watchdog_timeout_flag <= watchdog_timeout_flag;
                end
            end
        endcase
    end

    // Power-down mode. Any reset wakes the core. Halt beats a wake request in
    // the same cycle, so the core ends up asleep and waits for the next wake
    // event rather than missing the halt.
    always @(posedge ref_clk)
    begin
        if (next_cause != `CAUSE_NONE)
            power_down <= `MODE_RUN;
        else if (halt_exec)
            power_down <= `MODE_HALT;
        else if (wake_up)
            power_down <= `MODE_RUN;
    end

    // The reset strobes stand for each cycle in which a reinitialising cause
    // is active, so a held pin keeps the timers and interrupts off throughout.
    always @(posedge ref_clk)
    begin
        core_reset             <= core_init;
        interrupt_enable_clear <= core_init;
        watchdog_timer_restart <= core_init;
        timers_off             <= core_init;
    end

    // Ports come up as inputs, with data and direction bits at all ones.
    always @(posedge ref_clk)
    begin
        if (core_init)
        begin
            port_data <= `PORT_RESET;
            port_dir  <= `PORT_RESET;
        end
    end
endmodule // reset_state_and_flag_logic

//--- core/reset_state_map.vh
// Contract
// - Watchdog time-out in power-down clears program counter and stack pointer, sets flag.
// - Watchdog time-out flag and power-down flag live in the status register.
// - Power-on reset clears both the time-out flag and the power-down flag.
// - Pin or low-voltage reset in normal operation keeps both flags unchanged.
// - Watchdog reset in normal operation sets time-out flag, keeps power-down flag.
// - Watchdog reset during power-down sets both flags to one.
// - Power-on reset disables every interrupt source.
// - Power-on reset clears the watchdog counter, which then counts at once.
// - Power-on reset switches off all timer and event counters.
// - Power-on reset sets every port data and direction bit to ones.
// - Power-on reset points the stack pointer at the top of the stack.
// - Watchdog reset in normal operation equals a pin reset plus the time-out flag.
`ifndef RESET_STATE_MAP_VH
`define RESET_STATE_MAP_VH
`define PC_RESET      14'h0000
`define SP_RESET      3'h0
`define SP_TOP        3'h0
`define PORT_RESET    8'hFF
`define FLAG_SET      1'h1
`define FLAG_CLR      1'h0
`define PULSE_ON      1'h1
`define PULSE_OFF     1'h0
`define MODE_RUN      1'h0
`define MODE_HALT     1'h1
`define PIN_IDLE      2'h3
`define LVR_IDLE      2'h0
`define CAUSE_NONE    3'h0
`define CAUSE_POR     3'h1
`define CAUSE_PIN     3'h2
`define CAUSE_WDT_RUN 3'h3
`define CAUSE_WDT_PD  3'h4
`endif

//--- sim/reset_state_checker_sva.sv
`timescale 1ns/1ns
module reset_state_checker (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        power_on,
    input wire logic        external_reset_pin_n,
    input wire logic        low_voltage_reset,
    input wire logic        halt_exec,
    input wire logic        watchdog_timer_timeout,
    input wire logic        watchdog_clear,
    input wire logic        power_down,
    input wire logic        watchdog_timeout_flag,
    input wire logic        power_down_flag,
    input wire logic        timers_off,
    input wire logic        interrupt_enable_clear,
    input wire logic        watchdog_timer_restart,
    input wire logic [13:0] pc_value,
    input wire logic [2:0]  sp_value,
    input wire logic [2:0]  reset_cause,
    input wire logic [7:0]  port_data,
    input wire logic [7:0]  port_dir
);
    // Pin and supply resets lag two edges through the synchroniser; the history waits three to clear them.
    logic [2:0] hist;
    wire pin_ok = external_reset_pin_n & ~low_voltage_reset;
    wire quiet = &hist & pin_ok & ~power_on;
    wire wdt_pd = watchdog_timer_timeout & power_down & quiet;
    always @(posedge ref_clk) hist <= rst ? 3'h0 : {hist[1:0], pin_ok};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_por_flg; power_on |=> !watchdog_timeout_flag && !power_down_flag; endproperty
    a_por_flg: assert property (p_por_flg) else $error("por flags");
    property p_por_reg; power_on |=> pc_value == 14'h0000 && sp_value == 3'h0; endproperty
    a_por_reg: assert property (p_por_reg) else $error("por pc sp");
    property p_por_off; power_on |=> timers_off && interrupt_enable_clear; endproperty
    a_por_off: assert property (p_por_off) else $error("por off");
    property p_por_wdg; power_on |=> watchdog_timer_restart && port_dir == 8'hFF; endproperty
    a_por_wdg: assert property (p_por_wdg) else $error("por wdg");
    property p_pd_reg; wdt_pd |=> pc_value == 14'h0000 && sp_value == 3'h0 && reset_cause == 3'h4;
    endproperty
    a_pd_reg: assert property (p_pd_reg) else $error("pd regs");
    property p_pd_flg; wdt_pd |=> watchdog_timeout_flag && power_down_flag && $stable(port_data);
    endproperty
    a_pd_flg: assert property (p_pd_flg) else $error("pd flags");
    property p_run; watchdog_timer_timeout && !power_down && quiet |=> watchdog_timeout_flag
        && power_down_flag == $past(power_down_flag) && port_dir == 8'hFF; endproperty
    a_run: assert property (p_run) else $error("run wdt");
    property p_halt; halt_exec && !watchdog_timer_timeout && quiet |=> power_down_flag; endproperty
    a_halt: assert property (p_halt) else $error("halt");
    property p_pin; $fell(external_reset_pin_n) ##0 (!external_reset_pin_n && !(power_on |
        watchdog_timer_timeout | halt_exec | watchdog_clear))[*4] |=> reset_cause == 3'h2 &&
        $stable(watchdog_timeout_flag) && $stable(power_down_flag); endproperty
    a_pin: assert property (p_pin) else $error("pin");
endmodule // reset_state_checker
bind reset_state_and_flag_logic reset_state_checker reset_state_checker_inst (.*);

//--- sim/reset_switch_model.sv
`timescale 1ns/1ns
module reset_switch_model (
    input  wire logic ref_clk,
    input  wire logic press,
    output logic      external_reset_pin_n
);
    // The network pulls the pin high whenever the switch is open.
    always @(posedge ref_clk) external_reset_pin_n <= !press;
endmodule // reset_switch_model

//--- sim/tb.sv
`timescale 1ns/1ns
module tb;
    logic ref_clk, rst, power_on, low_voltage_reset, watchdog_timer_timeout, halt_exec;
    logic watchdog_clear, wake_up, press;
    wire external_reset_pin_n, core_reset, watchdog_timeout_flag, power_down_flag, power_down;
    wire interrupt_enable_clear, watchdog_timer_restart, timers_off;
    wire [13:0] pc_value;
    wire [2:0] sp_value, reset_cause;
    wire [7:0] port_data, port_dir;
    wire [7:0] flags = {6'h00, watchdog_timeout_flag, power_down_flag};
    int error_cnt = 0;
    int num_checks = 0;
    // Row: power-on, time-out, halt, clear, then the two flags expected.
    logic [5:0] rows [5] = '{6'h09, 6'h13, 6'h13, 6'h04, 6'h12};
    reset_state_and_flag_logic reset_state_and_flag_logic_inst (.*);
    reset_switch_model reset_switch_model_inst (.ref_clk, .press, .external_reset_pin_n);
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apply(input logic [3:0] s);
        @(posedge ref_clk) {power_on, watchdog_timer_timeout, halt_exec, watchdog_clear} <= s;
        @(posedge ref_clk) {power_on, watchdog_timer_timeout, halt_exec, watchdog_clear} <= 4'h0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial
    begin
        #20000;
        error_cnt++;
        finish_test;
    end
    initial
    begin
        {rst, power_on, low_voltage_reset, watchdog_timer_timeout, halt_exec} = 5'h10;
        {watchdog_clear, wake_up, press} = 3'h0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        foreach (rows[i])
        begin
            apply(rows[i][5:2]);
            check("flags", {6'h00, rows[i][1:0]}, flags);
        end
        $display("table done");
        @(posedge ref_clk) press <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 check("pin flags", 8'h02, flags);
        check("pin dir", 8'hFF, port_dir);
        check("pin cause", 8'h02, {5'h00, reset_cause});
        check("pin core reset", 8'h01, {7'h00, core_reset});
        @(posedge ref_clk) press <= 1'b0;
        $display("pin done");
        apply(4'h8);
        check("por flags", 8'h00, flags);
        check("por data", 8'hFF, port_data);
        check("por sp", 8'h00, {5'h00, sp_value});
        $display("por done");
        apply(4'h2);
        check("halt mode", 8'h01, {7'h00, power_down});
        @(posedge ref_clk) wake_up <= 1'b1;
        @(posedge ref_clk) wake_up <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 check("wake mode", 8'h00, {7'h00, power_down});
        check("wake flags", 8'h01, flags);
        $display("wake done");
        @(posedge ref_clk) rst <= 1'b1;
        @(posedge ref_clk) rst <= 1'b0;
        #1 check("rst flags", 8'h00, flags);
        check("rst timers", 8'h01, {7'h00, timers_off});
        repeat (3) @(posedge ref_clk);
        $display("reset done");
        finish_test;
    end
endmodule // tb
